// ### design/key_detect_pkg.sv
// Purpose: shared constants and types for the headset key press detector
// Assumes: 250 MHz clock, AHB-Lite register access, 8-bit resistance codes
// Notes: all offsets except NO_REG_OFFSET are byte addresses of aligned 32-bit words
package key_detect_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int PRESS_DEBOUNCE_NS = 32000;
  localparam int RELEASE_DEBOUNCE_NS = 16000;
  localparam int CONV_TIME_NS = 1000;
  localparam int PRESS_DEBOUNCE_CYC = (PRESS_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_DEBOUNCE_CYC = (RELEASE_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  // register offsets
  localparam logic [7:0] SETTINGS_OFFSET = 8'h00;
  localparam logic [7:0] KEY_INT_OFFSET = 8'h04;
  localparam logic [7:0] THRESH_OFFSET = 8'h08;
  localparam logic [7:0] ADC_OUT_OFFSET = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [7:0] NO_REG_OFFSET = 8'hFF;

  // settings fields
  localparam int SET_ENABLE_BIT = 0;
  localparam int SET_RAW_BIT = 1;
  localparam int SET_TRIGGER_BIT = 2;

  // key interrupt fields
  localparam int KEYS = 4;
  localparam int INT_PRESS_LSB = 0;
  localparam int INT_RELEASE_LSB = 4;
  localparam int INT_CONV_BIT = 8;
  localparam int INT_W = 9;
  localparam logic [INT_W-1:0] INT_RESET = 9'h000;

  // threshold fields and reset values, one code step per 6 ohm
  localparam int THR1_LSB = 0;
  localparam int THR2_LSB = 8;
  localparam int THR3_LSB = 16;
  localparam int DETECT_LSB = 24;
  localparam int OHMS_PER_STEP = 6;
  localparam int THR1_OHMS = 96;
  localparam logic [7:0] THR1_RESET = 8'(THR1_OHMS / OHMS_PER_STEP);
  localparam logic [7:0] THR2_RESET = 8'h20;
  localparam logic [7:0] THR3_RESET = 8'h30;
  localparam logic [7:0] DETECT_RESET = 8'h60;

  // adc output codes
  localparam logic [7:0] ADC_CLEAR = 8'h00;
  localparam logic [7:0] ADC_MIN_CODE = 8'h01;

  // status fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_SLEEVE_BIT = 8;
  localparam int STAT_CFG_BIT = 9;
  localparam int STAT_KEY_LSB = 16;

  // ahb
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam logic [23:0] HADDR_HIGH_ZERO = 24'h00_0000;

  typedef enum logic [5:0] {
    ST_OFF = 6'b000001,
    ST_WAIT_PRESS = 6'b000010,
    ST_PRESS_DB = 6'b000100,
    ST_CONVERT = 6'b001000,
    ST_HELD = 6'b010000,
    ST_RELEASE_DB = 6'b100000
  } detect_state_e;

endpackage : key_detect_pkg

// ### design/key_debounce_timer.sv
// Purpose: restartable cycle counter used for debounce and conversion time
// Assumes: clear is raised on every state change of the detector
// Notes: expired stays high until the next clear
`timescale 1ns/1ps
`default_nettype none
module key_debounce_timer
  import key_detect_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clear_in,
  input wire logic [TIMER_W-1:0] limit_in,
  output logic expired_out
);

  logic [TIMER_W-1:0] count;

  assign expired_out = (count == limit_in);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else if (clear_in) begin
      count <= '0;
    end else if (!expired_out) begin
      count <= count + 1'b1;
    end
  end

endmodule : key_debounce_timer
`default_nettype wire

// ### design/headset_key_press_detector.sv
// Purpose: headset key press and release detection with raw adc mode
// Assumes: adc_code_in is the resistance code of the monitored mic contact
// Notes: registers over ahb-lite, zero wait states, always okay
`timescale 1ns/1ps
`default_nettype none
module headset_key_press_detector
  import key_detect_pkg::*;
#(
  parameter int unsigned PRESS_DB_CYCLES = PRESS_DEBOUNCE_CYC,
  parameter int unsigned RELEASE_DB_CYCLES = RELEASE_DEBOUNCE_CYC
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [7:0] adc_code_in,
  input wire logic ring_to_mic_switch_in,
  input wire logic sleeve_to_mic_switch_in,
  input wire logic ring_to_ground_switch_in,
  input wire logic sleeve_to_ground_switch_in,
  input wire logic removal_event_in,
  output logic irq_out,
  output logic monitor_sleeve_out,
  output logic mic_config_ok_out
);

  function automatic logic [1:0] key_index(input logic [7:0] code, input logic [31:0] thr);
    if (code <= thr[THR1_LSB +: 8]) begin
      key_index = 2'd0;
    end else if (code <= thr[THR2_LSB +: 8]) begin
      key_index = 2'd1;
    end else if (code <= thr[THR3_LSB +: 8]) begin
      key_index = 2'd2;
    end else begin
      key_index = 2'd3;
    end
  endfunction : key_index

  function automatic logic [7:0] nonzero_code(input logic [7:0] code);
    nonzero_code = (code == ADC_CLEAR) ? ADC_MIN_CODE : code;
  endfunction : nonzero_code

  function automatic logic word_hit(input logic [7:0] word, input logic [7:0] offset);
    word_hit = (word == offset);
  endfunction : word_hit

  // reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // state
  detect_state_e state;
  detect_state_e next_state;
  logic enable;
  logic raw_mode;
  logic [31:0] thresh;
  logic [INT_W-1:0] key_int;
  logic [7:0] adc_out;
  logic [1:0] held_key;
  logic conv_manual;
  logic wr_pend;
  logic [7:0] wr_addr;

  logic next_enable;
  logic next_raw;
  logic [31:0] next_thresh;
  logic [INT_W-1:0] next_key_int;
  logic [7:0] next_adc;

  // bus decode
  wire addr_phase = hsel_in & hready_in & htrans_in[1];
  wire in_map = (haddr_in[31:8] == HADDR_HIGH_ZERO);
  wire [7:0] req_word = {haddr_in[7:2], 2'b00};
  wire rd_req = addr_phase & ~hwrite_in;
  // sub-word writes are dropped; only whole-word writes are supported
  wire wr_req = addr_phase & hwrite_in & (hsize_in == HSIZE_WORD);
  wire sel_settings = word_hit(req_word, SETTINGS_OFFSET);
  wire sel_key_int = word_hit(req_word, KEY_INT_OFFSET);
  wire sel_thresh = word_hit(req_word, THRESH_OFFSET);
  wire sel_adc = word_hit(req_word, ADC_OUT_OFFSET);
  wire sel_status = word_hit(req_word, STATUS_OFFSET);
  wire rd_int = rd_req & in_map & sel_key_int;
  wire wr_settings = wr_pend & word_hit(wr_addr, SETTINGS_OFFSET);
  wire wr_thresh = wr_pend & word_hit(wr_addr, THRESH_OFFSET);

  // settings effects
  wire disable_write = wr_settings & ~hwdata_in[SET_ENABLE_BIT];
  wire trigger = wr_settings & hwdata_in[SET_TRIGGER_BIT] & next_raw;

  assign next_enable = wr_settings ? hwdata_in[SET_ENABLE_BIT] : enable;
  // raw mode cannot outlive the enable bit
  assign next_raw = ~next_enable ? 1'b0 : (wr_settings ? hwdata_in[SET_RAW_BIT] : raw_mode);
  assign next_thresh = wr_thresh ? hwdata_in : thresh;

  // mic location from the switch matrix
  wire cfg_ring = ring_to_mic_switch_in & sleeve_to_ground_switch_in &
                  ~sleeve_to_mic_switch_in & ~ring_to_ground_switch_in;
  wire cfg_sleeve = sleeve_to_mic_switch_in & ring_to_ground_switch_in &
                    ~ring_to_mic_switch_in & ~sleeve_to_ground_switch_in;
  wire cfg_ok = cfg_ring | cfg_sleeve;

  // bias presence is the system's job; detection trusts the enable order
  wire detect_on = enable & mic_config_ok_out & ~removal_event_in;
  wire below = adc_code_in < thresh[DETECT_LSB +: 8];

  // timer shared by both debounce phases and the conversion
  logic timer_done;
  wire in_press_db = (state == ST_PRESS_DB);
  wire in_convert = (state == ST_CONVERT);
  wire in_held = (state == ST_HELD);
  wire in_release_db = (state == ST_RELEASE_DB);
  wire [TIMER_W-1:0] press_limit = TIMER_W'(PRESS_DB_CYCLES);
  wire [TIMER_W-1:0] release_limit = TIMER_W'(RELEASE_DB_CYCLES);
  wire [TIMER_W-1:0] conv_limit = TIMER_W'(CONV_CYC);
  wire timer_clear = (next_state != state);
  wire [TIMER_W-1:0] timer_limit =
    in_press_db ? press_limit : (in_release_db ? release_limit : conv_limit);

  key_debounce_timer timer_u (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .clear_in(timer_clear),
    .limit_in(timer_limit),
    .expired_out(timer_done)
  );

  always_comb begin
    next_state = state;
    if (!detect_on || disable_write) begin
      next_state = ST_OFF;
    end else begin
      case (state)
        ST_OFF: begin
          next_state = ST_WAIT_PRESS;
        end
        ST_WAIT_PRESS: begin
          if (below) begin
            next_state = ST_PRESS_DB;
          end
        end
        ST_PRESS_DB: begin
          if (!below) begin
            next_state = ST_WAIT_PRESS;
          end else if (timer_done) begin
            next_state = ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          if (timer_done) begin
            next_state = ST_HELD;
          end
        end
        ST_HELD: begin
          if (trigger) begin
            next_state = ST_CONVERT;
          end else if (!below) begin
            next_state = ST_RELEASE_DB;
          end
        end
        ST_RELEASE_DB: begin
          if (below) begin
            next_state = ST_HELD;
          end else if (timer_done) begin
            next_state = ST_WAIT_PRESS;
          end
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase
    end
  end

  // detection events
  wire conv_end = in_convert & (next_state == ST_HELD);
  wire press_event = conv_end & ~conv_manual;
  wire release_event = in_release_db & (next_state == ST_WAIT_PRESS);
  wire manual_start = in_held & (next_state == ST_CONVERT);
  wire [1:0] pressed_key = raw_mode ? 2'd0 : key_index(adc_code_in, thresh);

  // set beats a read clear in the same cycle; disable and removal beat all
  always_comb begin
    next_key_int = rd_int ? INT_RESET : key_int;
    if (press_event) begin
      next_key_int[INT_RELEASE_LSB + int'(pressed_key)] = 1'b0;
      next_key_int[INT_PRESS_LSB + int'(pressed_key)] = 1'b1;
    end
    if (release_event) begin
      next_key_int[INT_RELEASE_LSB + int'(held_key)] = 1'b1;
    end
    if (conv_end && raw_mode) begin
      next_key_int[INT_CONV_BIT] = 1'b1;
    end
    if (disable_write || removal_event_in) begin
      next_key_int = INT_RESET;
    end
  end

  // raw adc result; a read leaves it alone
  always_comb begin
    next_adc = adc_out;
    if (conv_end && raw_mode) begin
      next_adc = nonzero_code(adc_code_in);
    end
    if (!next_raw || removal_event_in) begin
      next_adc = ADC_CLEAR;
    end
  end

  // read mux sees pending writes so write then read returns the new value
  wire [31:0] settings_word = (32'(next_enable) << SET_ENABLE_BIT) |
                              (32'(next_raw) << SET_RAW_BIT);
  wire [31:0] status_word = (32'(state) << STAT_STATE_LSB) |
                            (32'(monitor_sleeve_out) << STAT_SLEEVE_BIT) |
                            (32'(mic_config_ok_out) << STAT_CFG_BIT) |
                            (32'(held_key) << STAT_KEY_LSB);
  wire [31:0] key_int_word = 32'(key_int);
  wire [31:0] adc_word = 32'(adc_out);
  wire [31:0] rd_value =
    !in_map ? 32'h0000_0000 :
    sel_settings ? settings_word :
    sel_key_int ? key_int_word :
    sel_thresh ? next_thresh :
    sel_adc ? adc_word :
    sel_status ? status_word : 32'h0000_0000;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= NO_REG_OFFSET;
      hrdata_out <= 32'h0000_0000;
    end else begin
      wr_pend <= wr_req;
      wr_addr <= (wr_req && in_map) ? req_word : NO_REG_OFFSET;
      hrdata_out <= rd_req ? rd_value : 32'h0000_0000;
    end
  end

  // every access finishes at once, so the response flops never move
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      enable <= 1'b0;
      raw_mode <= 1'b0;
      thresh <= {DETECT_RESET, THR3_RESET, THR2_RESET, THR1_RESET};
      key_int <= INT_RESET;
      adc_out <= ADC_CLEAR;
    end else begin
      enable <= next_enable;
      raw_mode <= next_raw;
      thresh <= next_thresh;
      key_int <= next_key_int;
      adc_out <= next_adc;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |next_key_int;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_OFF;
      held_key <= 2'd0;
      conv_manual <= 1'b0;
    end else begin
      state <= next_state;
      if (press_event) begin
        held_key <= pressed_key;
      end
      if (manual_start) begin
        conv_manual <= 1'b1;
      end else if (in_press_db) begin
        conv_manual <= 1'b0;
      end
    end
  end

  // layout is registered so a switch change cannot glitch the outputs
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      monitor_sleeve_out <= 1'b0;
      mic_config_ok_out <= 1'b0;
    end else begin
      monitor_sleeve_out <= cfg_sleeve;
      mic_config_ok_out <= cfg_ok;
    end
  end

endmodule : headset_key_press_detector
`default_nettype wire

// ### test/headset_line_model.sv
// Purpose: mic line and switch matrix on the far side of the detector
// Assumes: adc code follows the line level in the same cycle
// Notes: idle line sits near mic bias, above every press level
`timescale 1ns/1ps
`default_nettype none
module headset_line_model (
  input wire logic bias_on_in,
  input wire logic pressed_in,
  input wire logic sleeve_in,
  input wire logic float_in,
  input wire logic [7:0] key_code_in,
  output logic [7:0] adc_code_out,
  output logic ring_to_mic_out,
  output logic sleeve_to_mic_out,
  output logic ring_to_ground_out,
  output logic sleeve_to_ground_out
);
  // without bias the line reads low, so enable only after bias
  // idle level stands for the bias setting at or just above the codec output
  localparam logic [7:0] IDLE_CODE = 8'hF0;
  assign adc_code_out = !bias_on_in ? 8'h00 : (pressed_in ? key_code_in : IDLE_CODE);
  // one of the two legal mic layouts unless floated, switched together so no glitch
  // float opens all four switches, only while detection is off
  assign ring_to_mic_out = !sleeve_in & !float_in;
  assign sleeve_to_ground_out = !sleeve_in & !float_in;
  assign sleeve_to_mic_out = sleeve_in & !float_in;
  assign ring_to_ground_out = sleeve_in & !float_in;
endmodule : headset_line_model
`default_nettype wire

// ### test/headset_key_press_detector_asserts.sv
// Purpose: port level checks of the key press detector
// Assumes: single clock, bus ready tied to hreadyout
// Notes: helper flops track the ahb data phase
`timescale 1ns/1ps
`default_nettype none
module headset_key_press_detector_asserts
  import key_detect_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic ring_to_mic_switch_in,
  input wire logic sleeve_to_mic_switch_in,
  input wire logic ring_to_ground_switch_in,
  input wire logic sleeve_to_ground_switch_in,
  input wire logic removal_event_in,
  input wire logic irq_out,
  input wire logic monitor_sleeve_out,
  input wire logic mic_config_ok_out
);
  logic ap_wr, ap_rd, en_seen;
  logic [7:0] ap_a;
  wire take = hsel_in & hready_in & htrans_in[1];
  wire set_wr = ap_wr && (ap_a == SETTINGS_OFFSET);
  wire ring_lay = ring_to_mic_switch_in & !sleeve_to_mic_switch_in
    & !ring_to_ground_switch_in & sleeve_to_ground_switch_in;
  wire sleeve_lay = !ring_to_mic_switch_in & sleeve_to_mic_switch_in
    & ring_to_ground_switch_in & !sleeve_to_ground_switch_in;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ap_wr <= 1'b0;
      ap_rd <= 1'b0;
      ap_a <= 8'h00;
      en_seen <= 1'b0;
    end else begin
      ap_wr <= take & hwrite_in & (haddr_in[31:8] == HADDR_HIGH_ZERO);
      ap_rd <= take & !hwrite_in;
      ap_a <= haddr_in[7:0];
      en_seen <= en_seen | (set_wr & hwdata_in[SET_ENABLE_BIT]);
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  quiet_until_enable_a: assert property (!en_seen |-> !irq_out)
    else $error("irq raised before detection was enabled");
  disable_clears_a: assert property (set_wr && !hwdata_in[SET_ENABLE_BIT] |-> ##2 (!irq_out)[*3])
    else $error("irq still high after enable cleared");
  removal_clears_a: assert property (removal_event_in |-> ##2 !irq_out)
    else $error("irq still high after removal");
  read_clears_a: assert property (ap_rd && ap_a == KEY_INT_OFFSET |-> ##[1:2] !irq_out)
    else $error("irq still high after interrupt read");
  rdata_idle_a: assert property (!ap_rd |-> hrdata_out == 32'h0000_0000)
    else $error("read data outside a read data phase");
  unmapped_zero_a: assert property (ap_rd && ap_a == NO_REG_OFFSET |-> hrdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  bus_okay_a: assert property (hreadyout_out && !hresp_out)
    else $error("slave stalled or answered with an error");
  ring_layout_a: assert property (ring_lay[*6] |-> mic_config_ok_out && !monitor_sleeve_out)
    else $error("ring mic layout not recognised");
  sleeve_layout_a: assert property (sleeve_lay[*6] |-> mic_config_ok_out && monitor_sleeve_out)
    else $error("sleeve mic layout not recognised");
  bad_layout_a: assert property ((!ring_lay && !sleeve_lay)[*6] |-> !mic_config_ok_out)
    else $error("illegal layout accepted");
endmodule : headset_key_press_detector_asserts
bind headset_key_press_detector headset_key_press_detector_asserts
  headset_key_press_detector_asserts_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
  .ring_to_mic_switch_in(ring_to_mic_switch_in), .sleeve_to_mic_switch_in(sleeve_to_mic_switch_in),
  .ring_to_ground_switch_in(ring_to_ground_switch_in),
  .sleeve_to_ground_switch_in(sleeve_to_ground_switch_in), .removal_event_in(removal_event_in),
  .irq_out(irq_out), .monitor_sleeve_out(monitor_sleeve_out), .mic_config_ok_out(mic_config_ok_out));
`default_nettype wire

// ### test/headset_key_press_detector_bench.sv
// Purpose: self-checking bench of the key press detector
// Assumes: short debounce counts, bus answers without wait states
// Notes: presses are held long enough for debounce and conversion, except one 10-cycle bounce in t_single
`timescale 1ns/1ps
`default_nettype none
module headset_key_press_detector_bench
  import key_detect_pkg::*;
;
  localparam int PB = 20;
  localparam int RB = 10;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, bias = 1'b0, pressed = 1'b0, sleeve = 1'b0, removal = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
  logic [7:0] code = 8'h08;
  logic flt = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, irq, rm, sm, rg, sg;
  wire logic [7:0] adc;
  int err_count = 0, samples_checked = 0, cycles = 0;
  always #2 clk_in = ~clk_in;
  headset_line_model headset_line_model_i (.bias_on_in(bias), .pressed_in(pressed),
    .sleeve_in(sleeve), .float_in(flt), .key_code_in(code), .adc_code_out(adc),
    .ring_to_mic_out(rm), .sleeve_to_mic_out(sm), .ring_to_ground_out(rg),
    .sleeve_to_ground_out(sg));
  headset_key_press_detector #(.PRESS_DB_CYCLES(PB), .RELEASE_DB_CYCLES(RB))
    headset_key_press_detector_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(HSIZE_WORD),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .adc_code_in(adc), .ring_to_mic_switch_in(rm),
    .sleeve_to_mic_switch_in(sm), .ring_to_ground_switch_in(rg),
    .sleeve_to_ground_switch_in(sg), .removal_event_in(removal), .irq_out(irq),
    .monitor_sleeve_out(), .mic_config_ok_out());
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // a hang anywhere counts against the run
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clk_in);
    hsel <= 1'b1;
    haddr <= {HADDR_HIGH_ZERO, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0000_0000, q);
    chk(n, e, q);
  endtask : rd
  task automatic ci(input logic e);
    chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
  endtask : ci
  task automatic wait_irq();
    for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clk_in);
    ci(1'b1);
  endtask : wait_irq
  task automatic hold(input logic [7:0] c);
    @(posedge clk_in);
    code <= c;
    pressed <= 1'b1;
    repeat (400) @(posedge clk_in);
  endtask : hold
  task automatic let_go();
    pressed <= 1'b0;
    repeat (60) @(posedge clk_in);
  endtask : let_go
  task automatic t_reset();
    rd("thresh", THRESH_OFFSET, 32'h6030_2010);
    rd("adc", ADC_OUT_OFFSET, 32'h0000_0000);
    rd("unmapped", NO_REG_OFFSET, 32'h0000_0000);
    repeat (400) @(posedge clk_in);
    ci(1'b0);
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0000);
    flt <= 1'b1;
    repeat (8) @(posedge clk_in);
    rd("status", STATUS_OFFSET, 32'h0000_0001);
    flt <= 1'b0;
    repeat (8) @(posedge clk_in);
    rd("status", STATUS_OFFSET, 32'h0000_0201);
  endtask : t_reset
  task automatic t_single();
    bias <= 1'b1;
    wr(SETTINGS_OFFSET, 32'h0000_0001);
    @(posedge clk_in);
    code <= 8'h08;
    pressed <= 1'b1;
    repeat (10) @(posedge clk_in);
    pressed <= 1'b0;
    @(posedge clk_in);
    pressed <= 1'b1;
    repeat (266) @(posedge clk_in);
    ci(1'b0);
    wait_irq();
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0001);
    repeat (2) @(posedge clk_in);
    ci(1'b0);
    let_go();
    ci(1'b1);
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0010);
  endtask : t_single
  task automatic t_multi();
    sleeve <= 1'b1;
    hold(8'h08);
    let_go();
    hold(8'h18);
    let_go();
    hold(8'h08);
    ci(1'b1);
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0023);
    let_go();
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0010);
  endtask : t_multi
  task automatic t_raw();
    hold(8'h08);
    wr(SETTINGS_OFFSET, 32'h0000_0003);
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0001);
    let_go();
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0010);
    hold(8'h2A);
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0101);
    rd("adc", ADC_OUT_OFFSET, 32'h0000_002A);
    rd("adc", ADC_OUT_OFFSET, 32'h0000_002A);
    code <= 8'h00;
    wr(SETTINGS_OFFSET, 32'h0000_0007);
    repeat (300) @(posedge clk_in);
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0100);
    rd("adc", ADC_OUT_OFFSET, 32'h0000_0001);
    wr(SETTINGS_OFFSET, 32'h0000_0001);
    rd("adc", ADC_OUT_OFFSET, 32'h0000_0000);
    let_go();
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0010);
  endtask : t_raw
  task automatic t_clear();
    hold(8'h18);
    wr(SETTINGS_OFFSET, 32'h0000_0000);
    repeat (3) @(posedge clk_in);
    ci(1'b0);
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0000);
    let_go();
    wr(SETTINGS_OFFSET, 32'h0000_0001);
    hold(8'h08);
    ci(1'b1);
    removal <= 1'b1;
    @(posedge clk_in);
    removal <= 1'b0;
    repeat (3) @(posedge clk_in);
    ci(1'b0);
    rd("key_int", KEY_INT_OFFSET, 32'h0000_0000);
    let_go();
  endtask : t_clear
  initial begin
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_single();
    t_multi();
    t_raw();
    t_clear();
    print_verdict();
  end
endmodule : headset_key_press_detector_bench
`default_nettype wire
